/* hw/ebac_ctrl.sv */
// Top of the external bank access controller: registers and sequencer
// What this block does
// - Decode only the lower 26 address bits
// - Bank bits 25:24 pick bank and strobes
// - Strap at reset maps low bank 0 ROM
// - Second bank 0 region goes to RAM
// - Third bank 0 region goes to core registers
// - Next megabyte goes to peripheral registers
// - Upper bank 0 and bank 1 are external
// - DRAM banks get row, column strobes, muxed address
// - Per-bank 8/16 width; internal fixed widths
// - Bank 0 width loads from boot strap
// - Split wide accesses into 2 or 4 beats
// - SRAM beat: read one cycle, write two
// - Zero to seven programmable SRAM waits per bank
// - Enabled external wait sampled on clock edges
// - Byte method bit swaps SRAM strobe pins
// - Row phase shifts address by 8 to 11
// - Each DRAM beat takes two cycles
// - Trace bit stalls core, shows core bus
// - SRAM banks get selects, read, write strobes
// - DRAM bit swaps write and column strobes
//
// Added by the designer: the address map and the plain strobed port.
module ebac_ctrl import ebac_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Straps
	input wire logic ext_rom_select_n,
	input wire logic boot_width_pin,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Core bus
	input wire ebac_core_req_t core_req,
	output logic core_busy,
	output logic core_ready,
	output logic [31:0] core_rdata,
	// Internal areas
	output ebac_int_req_t int_req,
	input wire logic int_ack,
	input wire logic [31:0] int_rdata,
	// External bus
	output logic [25:0] external_address,
	output logic [15:0] xd_out,
	output logic xd_oe,
	input wire logic [15:0] xd_in,
	input wire logic external_wait_n,
	// SRAM strobes
	output logic chip_select_bank0_n,
	output logic chip_select_bank1_n,
	output logic read_strobe_n,
	output logic wre_or_wrl_n,
	output logic hb_or_wrh_n,
	output logic lb_or_a0,
	// DRAM strobes
	output logic ras_n,
	output logic cas_or_casl_n,
	output logic we_or_wl_n,
	output logic cash_or_wh_n
);
	logic [7:0] bus_width_register_r;
	logic [7:0] sram_wait_register_r;
	logic [7:0] wait_input_enable_register_r;
	logic [7:0] byte_method_register_r;
	logic [7:0] dram_bank_control_r [2];
	logic [7:0] cycle_trace_control_r;
	logic rom_internal_r;
	ebac_state_t state_r;
	ebac_tgt_t tgt_r;
	ebac_tgt_t dec_tgt;
	logic we_r;
	logic [1:0] size_r;
	logic [25:0] addr_r;
	logic [31:0] wdata_r;
	logic [31:0] rdata_r;
	logic [1:0] wlog_r;
	logic [1:0] beat_r;
	logic [3:0] cyc_r;
	logic first_r;
	logic [15:0] xd_r;
	logic [25:0] beat_addr;
	logic [25:0] mux_addr;
	logic trace_on;
	logic bank1;
	logic dram3;
	logic wait_en;
	logic hold;
	logic beat_end;
	logic last;
	logic method;
	logic dmethod;
	logic hi_en;
	logic lo_en;
	logic [3:0] pw;
	logic [4:0] lane_sh;
	logic [1:0] new_wlog;

	ebac_decode u_decode (
		.addr(core_req.addr[25:0]),
		.rom_internal(rom_internal_r),
		.target(dec_tgt)
	);

	ebac_row_mux u_row_mux (
		.addr(beat_addr),
		.shift_sel(dram_bank_control_r[dram3][1:0]),
		.row_phase(state_r == S_ROW),
		.mux_addr(mux_addr)
	);

	// Bank and access qualifiers of the current beat
	always_comb begin
		trace_on = cycle_trace_control_r[TRACE_BIT];
		bank1 = (tgt_r == TGT_EXT1);
		dram3 = (tgt_r == TGT_DRAM3);
		wait_en = wait_input_enable_register_r[bank1];
		hold = wait_en && !external_wait_n;
		pw = bank1 ? {1'b0, sram_wait_register_r[PW1_LSB +: 3]} :
			{1'b0, sram_wait_register_r[2:0]};
		method = byte_method_register_r[bank1];
		dmethod = dram_bank_control_r[dram3][DRAM_METHOD_BIT];
		lane_sh = 5'({beat_r, 3'h0} << wlog_r);
		beat_addr = addr_r + 26'({beat_r} << wlog_r);
		last = (beat_r == last_beat(size_r, wlog_r));
		hi_en = (wlog_r == W16) && (size_r != W8 || beat_addr[0]);
		lo_en = (wlog_r == W8) || size_r != W8 || !beat_addr[0];
	end

	// Width of the target bus for a fresh request
	always_comb begin
		case (dec_tgt)
			TGT_IROM, TGT_IRAM, TGT_CORE: new_wlog = W32;
			TGT_PERIPH: new_wlog = W16;
			TGT_RSVD: new_wlog = W32;
			default: new_wlog = bus_width_register_r[core_req.addr[25:24]] ?
				W16 : W8;
		endcase
	end

	// End of a beat for each kind of target
	always_comb begin
		case (state_r)
			S_SRAM: beat_end = (cyc_r == 4'h0) && !hold;
			S_COL: beat_end = 1'b1;
			S_INT: beat_end = int_ack;
			default: beat_end = 1'b0;
		endcase
	end

	// Straps are caught while reset is held
	always_ff @(posedge clk) begin
		if (rst) begin
			rom_internal_r <= ext_rom_select_n;
		end
	end

	// Software registers
	always_ff @(posedge clk) begin
		if (rst) begin
			bus_width_register_r <= {7'h00, boot_width_pin};
			sram_wait_register_r <= RST_ZERO;
			wait_input_enable_register_r <= RST_ZERO;
			byte_method_register_r <= RST_ZERO;
			dram_bank_control_r[0] <= RST_ZERO;
			dram_bank_control_r[1] <= RST_ZERO;
			cycle_trace_control_r <= RST_ZERO;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_BUS_WIDTH: bus_width_register_r <= reg_wdata;
				OFS_SRAM_WAIT: sram_wait_register_r <= reg_wdata;
				OFS_WAIT_EN: wait_input_enable_register_r <= reg_wdata;
				OFS_BYTE_METHOD: byte_method_register_r <= reg_wdata;
				OFS_DRAM2: dram_bank_control_r[0] <= reg_wdata;
				OFS_DRAM3: dram_bank_control_r[1] <= reg_wdata;
				OFS_TRACE: cycle_trace_control_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read data one cycle after the read strobe, zero when unmapped
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= RST_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
				OFS_BUS_WIDTH: reg_rdata <= bus_width_register_r;
				OFS_SRAM_WAIT: reg_rdata <= sram_wait_register_r;
				OFS_WAIT_EN: reg_rdata <= wait_input_enable_register_r;
				OFS_BYTE_METHOD: reg_rdata <= byte_method_register_r;
				OFS_DRAM2: reg_rdata <= dram_bank_control_r[0];
				OFS_DRAM3: reg_rdata <= dram_bank_control_r[1];
				OFS_TRACE: reg_rdata <= cycle_trace_control_r;
				default: reg_rdata <= RST_ZERO;
			endcase
		end else begin
			reg_rdata <= RST_ZERO;
		end
	end

	// Access sequencer: take, split into beats, finish
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= S_IDLE;
			tgt_r <= TGT_EXT0;
			we_r <= 1'b0;
			size_r <= 2'h0;
			addr_r <= 26'h0000000;
			wdata_r <= 32'h00000000;
			wlog_r <= W8;
			beat_r <= 2'h0;
			cyc_r <= 4'h0;
			first_r <= 1'b0;
		end else begin
			case (state_r)
				S_IDLE: begin
					if (core_req.valid && !trace_on) begin
						tgt_r <= dec_tgt;
						we_r <= core_req.we;
						size_r <= core_req.size;
						addr_r <= core_req.addr[25:0];
						wdata_r <= core_req.wdata;
						wlog_r <= new_wlog;
						beat_r <= 2'h0;
						first_r <= 1'b1;
						cyc_r <= (core_req.we ? SRAM_WR_BASE : SRAM_RD_BASE) +
							(core_req.addr[24] ?
							{1'b0, sram_wait_register_r[PW1_LSB +: 3]} :
							{1'b0, sram_wait_register_r[2:0]});
						case (dec_tgt)
							TGT_EXT0, TGT_EXT1: state_r <= S_SRAM;
							TGT_DRAM2, TGT_DRAM3: state_r <= S_ROW;
							TGT_RSVD: state_r <= S_DONE;
							default: state_r <= S_INT;
						endcase
					end
				end
				S_SRAM: begin
					first_r <= 1'b0;
					if (cyc_r != 4'h0) begin
						cyc_r <= cyc_r - 4'h1;
					end
				end
				S_ROW: state_r <= S_COL;
				S_DONE: state_r <= S_IDLE;
				default: ;
			endcase
			if (beat_end) begin
				if (last) begin
					state_r <= S_DONE;
				end else begin
					beat_r <= beat_r + 2'h1;
					first_r <= 1'b1;
					cyc_r <= (we_r ? SRAM_WR_BASE : SRAM_RD_BASE) + pw;
					state_r <= (state_r == S_COL) ? S_ROW : state_r;
				end
			end
		end
	end

	// Read lanes gather into the core word
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_r <= 32'h00000000;
		end else if (state_r == S_IDLE) begin
			rdata_r <= 32'h00000000;
		end else if (beat_end && !we_r) begin
			case (wlog_r)
				W32: rdata_r <= int_rdata;
				W16: rdata_r[lane_sh +: 16] <= (state_r == S_INT) ?
					int_rdata[15:0] : xd_in;
				default: rdata_r[lane_sh +: 8] <= xd_in[7:0];
			endcase
		end
	end

	// Write lanes, byte copied onto both lanes on 16 bits
	always_ff @(posedge clk) begin
		if (rst) begin
			xd_r <= 16'h0000;
		end else if (trace_on) begin
			xd_r <= core_req.wdata[15:0];
		end else if (wlog_r == W16 && size_r == W8) begin
			xd_r <= {wdata_r[7:0], wdata_r[7:0]};
		end else begin
			xd_r <= 16'(wdata_r >> lane_sh);
		end
	end

	// Core side answers
	always_comb begin
		core_busy = (state_r != S_IDLE) || trace_on;
		core_ready = (state_r == S_DONE);
		core_rdata = rdata_r;
		int_req.valid = (state_r == S_INT);
		int_req.we = we_r;
		int_req.target = tgt_r;
		int_req.addr = beat_addr;
		int_req.wdata = wdata_r;
	end

	// External address and data pins
	always_comb begin
		xd_out = xd_r;
		if (trace_on) begin
			external_address = core_req.addr[25:0];
			xd_oe = 1'b1;
		end else begin
			external_address = mux_addr;
			xd_oe = we_r && (state_r == S_SRAM || state_r == S_COL);
		end
	end

	// SRAM bank strobes
	always_comb begin
		chip_select_bank0_n = !(state_r == S_SRAM && !bank1);
		chip_select_bank1_n = !(state_r == S_SRAM && bank1);
		read_strobe_n = !(state_r == S_SRAM && !we_r);
		wre_or_wrl_n = 1'b1;
		hb_or_wrh_n = 1'b1;
		lb_or_a0 = beat_addr[0];
		if (state_r == S_SRAM) begin
			if (!method) begin
				wre_or_wrl_n = !(we_r && !first_r);
				hb_or_wrh_n = !hi_en;
				lb_or_a0 = !lo_en;
			end else begin
				wre_or_wrl_n = !(we_r && !first_r && lo_en);
				hb_or_wrh_n = !(we_r && !first_r && hi_en);
			end
		end
	end

	// DRAM bank strobes
	always_comb begin
		ras_n = !(state_r == S_ROW || state_r == S_COL);
		cas_or_casl_n = 1'b1;
		we_or_wl_n = 1'b1;
		cash_or_wh_n = 1'b1;
		if (state_r == S_COL) begin
			if (dmethod) begin
				cas_or_casl_n = 1'b0;
				we_or_wl_n = !(we_r && lo_en);
				cash_or_wh_n = !(we_r && hi_en);
			end else begin
				cas_or_casl_n = !lo_en;
				we_or_wl_n = !we_r;
				cash_or_wh_n = !hi_en;
			end
		end
	end

	// Cycles spent in the current SRAM beat, and holds seen in it
	logic [4:0] beat_len_r;
	logic [3:0] holds_r;
	always_ff @(posedge clk) begin
		if (rst || state_r != S_SRAM || beat_end) begin
			beat_len_r <= 5'h01;
			holds_r <= 4'h0;
		end else begin
			beat_len_r <= beat_len_r + 5'h01;
			holds_r <= holds_r + 4'(cyc_r == 4'h0 && hold);
		end
	end

	sequence s_row;
		state_r == S_ROW && !ras_n;
	endsequence
	sequence s_col;
		state_r == S_COL && !ras_n;
	endsequence

	property p_trace_stall;
		@(posedge clk) disable iff (rst)
		trace_on |-> core_busy && !core_ready;
	endproperty
	a_trace_stall: assert property (p_trace_stall)
		else $error("trace mode does not stall the core");

	property p_dram_two;
		@(posedge clk) disable iff (rst)
		$rose(state_r == S_ROW) |-> s_row ##1 s_col ##1 state_r != S_COL;
	endproperty
	a_dram_two: assert property (p_dram_two)
		else $error("DRAM beat is not two cycles");

	property p_sram_len;
		@(posedge clk) disable iff (rst)
		(state_r == S_SRAM && beat_end) |->
			beat_len_r == 5'(5'(we_r ? SRAM_WR_BASE : SRAM_RD_BASE) +
			5'(pw) + 5'(holds_r) + 5'h01);
	endproperty
	a_sram_len: assert property (p_sram_len)
		else $error("SRAM beat length wrong");

	property p_split;
		@(posedge clk) disable iff (rst)
		$rose(core_ready) && tgt_r != TGT_RSVD |->
			beat_r == last_beat(size_r, wlog_r);
	endproperty
	a_split: assert property (p_split)
		else $error("wrong number of beats");

	property p_width_strap;
		@(posedge clk) $fell(rst) |->
			bus_width_register_r[0] == $past(boot_width_pin);
	endproperty
	a_width_strap: assert property (p_width_strap)
		else $error("bank 0 width not taken from strap");

	property p_ram;
		@(posedge clk) disable iff (rst)
		core_req.addr[25:21] == 5'h01 |-> dec_tgt == TGT_IRAM;
	endproperty
	a_ram: assert property (p_ram)
		else $error("RAM region misrouted");

	property p_core_regs;
		@(posedge clk) disable iff (rst)
		core_req.addr[25:21] == 5'h02 |-> dec_tgt == TGT_CORE;
	endproperty
	a_core_regs: assert property (p_core_regs)
		else $error("core register region misrouted");

	property p_periph;
		@(posedge clk) disable iff (rst)
		core_req.addr[25:20] == 6'h06 |-> dec_tgt == TGT_PERIPH &&
			new_wlog == W16;
	endproperty
	a_periph: assert property (p_periph)
		else $error("peripheral region misrouted");

	property p_rom;
		@(posedge clk) disable iff (rst)
		core_req.addr[25:21] == 5'h00 |->
			dec_tgt == (rom_internal_r ? TGT_IROM : TGT_EXT0);
	endproperty
	a_rom: assert property (p_rom)
		else $error("ROM region misrouted");

	property p_select;
		@(posedge clk) disable iff (rst)
		!chip_select_bank1_n |-> state_r == S_SRAM && tgt_r == TGT_EXT1 &&
			chip_select_bank0_n;
	endproperty
	a_select: assert property (p_select)
		else $error("bank 1 select without bank 1 access");
endmodule // ebac_ctrl

/* hw/ebac_decode.sv */
// Bank and bank 0 region decoder
module ebac_decode import ebac_pkg::*; (
	// Address and strap
	input wire logic [25:0] addr,
	input wire logic rom_internal,
	// Result
	output ebac_tgt_t target
);
	// Bank bits choose the bank, bank 0 splits further by region
	always_comb begin
		target = TGT_EXT0;
		case (addr[25:24])
			BANK_SRAM0: begin
				case (addr[23:20])
					REG_ROM_A, REG_ROM_B: target = rom_internal ?
						TGT_IROM : TGT_EXT0;
					REG_RAM_A, REG_RAM_B: target = TGT_IRAM;
					REG_CORE_A, REG_CORE_B: target = TGT_CORE;
					REG_PERIPH: target = TGT_PERIPH;
					REG_RSVD: target = TGT_RSVD;
					default: target = TGT_EXT0;
				endcase
			end
			BANK_SRAM1: target = TGT_EXT1;
			BANK_DRAM2: target = TGT_DRAM2;
			default: target = TGT_DRAM3;
		endcase
	end
endmodule // ebac_decode

/* hw/ebac_pkg.sv */
// Shared constants, types and helpers of the external bank access controller
package ebac_pkg;
	// Register offsets on the plain register port
	localparam logic [7:0] OFS_BUS_WIDTH = 8'h00;
	localparam logic [7:0] OFS_SRAM_WAIT = 8'h04;
	localparam logic [7:0] OFS_WAIT_EN = 8'h08;
	localparam logic [7:0] OFS_BYTE_METHOD = 8'h0C;
	localparam logic [7:0] OFS_DRAM2 = 8'h10;
	localparam logic [7:0] OFS_DRAM3 = 8'h14;
	localparam logic [7:0] OFS_TRACE = 8'h18;
	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	// Field positions
	localparam int TRACE_BIT = 0;
	localparam int PW1_LSB = 4;
	localparam int DRAM_METHOD_BIT = 2;
	// Bank 0 region codes on address bits 23:20
	localparam logic [3:0] REG_ROM_A = 4'h0;
	localparam logic [3:0] REG_ROM_B = 4'h1;
	localparam logic [3:0] REG_RAM_A = 4'h2;
	localparam logic [3:0] REG_RAM_B = 4'h3;
	localparam logic [3:0] REG_CORE_A = 4'h4;
	localparam logic [3:0] REG_CORE_B = 4'h5;
	localparam logic [3:0] REG_PERIPH = 4'h6;
	localparam logic [3:0] REG_RSVD = 4'h7;
	// Bank codes on address bits 25:24
	localparam logic [1:0] BANK_SRAM0 = 2'h0;
	localparam logic [1:0] BANK_SRAM1 = 2'h1;
	localparam logic [1:0] BANK_DRAM2 = 2'h2;
	// Base cycle counts of an SRAM bank beat, minus one
	localparam logic [3:0] SRAM_RD_BASE = 4'h0;
	localparam logic [3:0] SRAM_WR_BASE = 4'h1;
	// Row shift offset: field value 0..3 means 8..11 bits
	localparam logic [4:0] ROW_SHIFT_MIN = 5'h08;
	// Log2 of bus width in bytes
	localparam logic [1:0] W8 = 2'h0;
	localparam logic [1:0] W16 = 2'h1;
	localparam logic [1:0] W32 = 2'h2;

	typedef enum logic [3:0] {
		TGT_EXT0 = 4'h0,
		TGT_EXT1 = 4'h1,
		TGT_DRAM2 = 4'h2,
		TGT_DRAM3 = 4'h3,
		TGT_IROM = 4'h4,
		TGT_IRAM = 4'h5,
		TGT_CORE = 4'h6,
		TGT_PERIPH = 4'h7,
		TGT_RSVD = 4'h8
	} ebac_tgt_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_SRAM = 3'h1,
		S_ROW = 3'h2,
		S_COL = 3'h3,
		S_INT = 3'h4,
		S_DONE = 3'h5
	} ebac_state_t;

	// Core bus request: size 0 byte, 1 half word, 2 word
	typedef struct packed {
		logic valid;
		logic we;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} ebac_core_req_t;

	// Request towards internal ROM, RAM and register areas
	typedef struct packed {
		logic valid;
		logic we;
		ebac_tgt_t target;
		logic [25:0] addr;
		logic [31:0] wdata;
	} ebac_int_req_t;

	// Number of beats minus one for an access of a size on a bus width
	function automatic logic [1:0] last_beat(logic [1:0] size,
		logic [1:0] wlog);
		logic [1:0] d;
		d = (size > wlog) ? 2'(size - wlog) : 2'h0;
		case (d)
			2'h1: last_beat = 2'h1;
			2'h2: last_beat = 2'h3;
			default: last_beat = 2'h0;
		endcase
	endfunction
endpackage

/* hw/ebac_row_mux.sv */
// Row and column address multiplexer for the DRAM banks
module ebac_row_mux import ebac_pkg::*; (
	// Inputs
	input wire logic [25:0] addr,
	input wire logic [1:0] shift_sel,
	input wire logic row_phase,
	// Multiplexed address
	output logic [25:0] mux_addr
);
	logic [4:0] amount;

	// Row phase puts address bit shift+k on output k, upper bits zero
	always_comb begin
		amount = ROW_SHIFT_MIN + {3'h0, shift_sel};
		if (row_phase) begin
			mux_addr = {2'h0, addr[23:0] >> amount};
		end else begin
			mux_addr = addr;
		end
	end
endmodule // ebac_row_mux

/* verif/ebac_ctrl_tb.sv */
// Self-checking bench of the external bank access controller
module ebac_ctrl_tb import ebac_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, ext_rom_select_n = 1'b1, boot_width_pin = 1'b1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic reg_wr = 1'b0, reg_rd = 1'b0, core_busy, core_ready, int_ack;
	ebac_core_req_t core_req = '0;
	ebac_int_req_t int_req;
	logic [31:0] core_rdata, int_rdata, wr_cnt;
	logic [25:0] external_address, row_cap;
	logic [15:0] xd_out, xd_in, wr_data;
	logic xd_oe, external_wait_n, chip_select_bank0_n, chip_select_bank1_n;
	logic read_strobe_n, wre_or_wrl_n, hb_or_wrh_n, lb_or_a0;
	logic ras_n, cas_or_casl_n, we_or_wl_n, cash_or_wh_n;
	logic [2:0] wr_pins, dpins;
	logic [3:0] slow = 4'h0;
	int err_count = 0, compares = 0, cyc = 0;
	typedef struct {logic [1:0] sz; logic [31:0] a, exp, msk; int n;} ebac_row_t;
	// Reads: size, address, data, mask, cycles to ready (0 = not checked)
	ebac_row_t rows[14] = '{
		'{2'h0, 32'h0080_0010, 32'h4A, 32'hFF, 2},
		'{2'h0, 32'h0080_0011, 32'hD200, 32'hFF00, 2},
		'{2'h1, 32'hFC80_0020, 32'hE37A, 32'hFFFF, 2},
		'{2'h2, 32'h0080_0040, 32'h8118_831A, 32'hFFFF_FFFF, 3},
		'{2'h0, 32'h0100_0008, 32'h52, 32'hFF, 2},
		'{2'h2, 32'h0100_0010, 32'h4948_4B4A, 32'hFFFF_FFFF, 5},
		'{2'h1, 32'h0100_0004, 32'h5F5E, 32'hFFFF, 3},
		'{2'h0, 32'h0200_0030, 32'h6A, 32'hFF, 3},
		'{2'h2, 32'h0300_0000, 32'h5958_5B5A, 32'hFFFF_FFFF, 9},
		'{2'h2, 32'h0000_0100, 32'h100, 32'hFFFF_FFFF, 0},
		'{2'h2, 32'h0020_0080, 32'h20_0080, 32'hFFFF_FFFF, 0},
		'{2'h2, 32'h0040_0010, 32'h40_0010, 32'hFFFF_FFFF, 0},
		'{2'h1, 32'h0060_0004, 32'h4, 32'hFFFF, 0},
		'{2'h2, 32'h0070_0000, 32'h0, 32'hFFFF_FFFF, 1}};
	logic [7:0] wv[8] = '{8'h0F, 8'h77, 8'h03, 8'h03, 8'h07, 8'h07, 8'h01, 8'hFF};

	ebac_ctrl ebac_ctrl_i (.clk, .rst, .ext_rom_select_n, .boot_width_pin,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_req,
		.core_busy, .core_ready, .core_rdata, .int_req, .int_ack, .int_rdata,
		.external_address, .xd_out, .xd_oe, .xd_in, .external_wait_n,
		.chip_select_bank0_n, .chip_select_bank1_n, .read_strobe_n,
		.wre_or_wrl_n, .hb_or_wrh_n, .lb_or_a0, .ras_n, .cas_or_casl_n,
		.we_or_wl_n, .cash_or_wh_n);
	ebac_ext_model ebac_ext_model_i (.clk, .rst, .external_address, .xd_out,
		.chip_select_bank0_n, .chip_select_bank1_n, .read_strobe_n,
		.wre_or_wrl_n, .hb_or_wrh_n, .lb_or_a0, .ras_n, .cas_or_casl_n,
		.we_or_wl_n, .cash_or_wh_n, .int_req, .slow, .xd_in, .external_wait_n,
		.int_ack, .int_rdata, .wr_data, .wr_pins, .dpins, .row_cap, .wr_cnt);

	// 20 MHz clock
	always #25 clk = ~clk;

	// Cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic rw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rr(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// One core access; n counts edges from the launch to ready
	task automatic access(input logic we, input logic [1:0] sz,
		input logic [31:0] a, input logic [31:0] d, output int n,
		output logic [31:0] rd);
		@(posedge clk);
		core_req <= '{1'b1, we, sz, a, d};
		@(posedge clk);
		core_req.valid <= 1'b0;
		n = 1;
		#1;
		while (core_ready !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (core_ready !== 1'b1) err_count++; // Limit ran out
		rd = core_rdata;
	endtask

	task automatic conclude();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Main sequence
	initial begin
		int n;
		logic [31:0] rd, c;
		logic [7:0] r;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		// Reset values, write and read back, unmapped place last
		for (int i = 0; i < 8; i++) begin
			rr(8'(i * 4), r);
			chk(32'(r), i == 0 ? 32'h1 : 32'h0);
		end
		foreach (wv[i]) begin
			rw(8'(i * 4), wv[i]);
			rr(8'(i * 4), r);
			chk(32'(r), i == 7 ? 32'h0 : 32'(wv[i]));
			rw(8'(i * 4), i == 0 ? 8'h01 : 8'h00);
		end
		foreach (rows[i]) begin
			access(1'b0, rows[i].sz, rows[i].a, 32'h0, n, rd);
			chk(rd & rows[i].msk, rows[i].exp);
			if (rows[i].n != 0) chk(32'(n), 32'(rows[i].n));
		end
		// Programmed waits for bank 0 only
		rw(OFS_SRAM_WAIT, 8'h07);
		access(1'b0, 2'h0, 32'h0080_0010, 32'h0, n, rd);
		chk(32'(n), 32'h9);
		access(1'b0, 2'h0, 32'h0100_0008, 32'h0, n, rd);
		chk(32'(n), 32'h2);
		rw(OFS_SRAM_WAIT, 8'h00);
		// Slow device on bank 1, enable off then on
		slow = 4'h3;
		for (int e = 1; e < 4; e += 2) begin
			rw(OFS_WAIT_EN, 8'(e));
			access(1'b0, 2'h0, 32'h0100_0008, 32'h0, n, rd);
			chk(32'(n), e == 3 ? 32'h5 : 32'h2);
		end
		slow = 4'h0;
		rw(OFS_WAIT_EN, 8'h00);
		// Byte write on the 8-bit bank: two cycles, one strobe cycle
		c = wr_cnt;
		access(1'b1, 2'h0, 32'h0100_0003, 32'hA5, n, rd);
		chk({8'h0, wr_data[7:0], 8'(wr_cnt - c), 8'(n)}, 32'hA5_0103);
		// Odd byte write, both methods set alike for the two banks
		for (int m = 0; m < 2; m++) begin
			rw(OFS_BYTE_METHOD, m ? 8'h03 : 8'h00);
			access(1'b1, 2'h0, 32'h0080_0001, 32'hA5, n, rd);
			chk({wr_data, 13'h0, wr_pins}, {16'hA5A5, 13'h0, m ? 3'h5 : 3'h1});
		end
		// Row address for every shift
		for (int s = 0; s < 4; s++) begin
			rw(OFS_DRAM2, 8'(s));
			access(1'b0, 2'h0, 32'h02AB_CDEF, 32'h0, n, rd);
			chk(32'(row_cap), 32'(24'hAB_CDEF >> (8 + s)));
			chk(rd & 32'hFF, 32'hB5);
		end
		// DRAM strobe methods on a 16-bit bank 3
		rw(OFS_BUS_WIDTH, 8'h09);
		for (int m = 0; m < 2; m++) begin
			rw(OFS_DRAM3, m ? 8'h04 : 8'h00);
			access(1'b1, 2'h0, 32'h0300_0011, 32'h5C, n, rd);
			chk(32'(dpins), m ? 32'h2 : 32'h4);
		end
		rw(OFS_BUS_WIDTH, 8'h01);
		// Trace shows the core address and stalls the core
		rw(OFS_TRACE, 8'h01);
		@(posedge clk);
		core_req.addr <= 32'hFD12_3456;
		core_req.wdata <= 32'h0000_BEEF;
		repeat (2) @(posedge clk);
		#1;
		chk({core_busy, 5'h0, external_address}, 32'h8112_3456);
		chk({15'h0, xd_oe, xd_out}, 32'h0001_BEEF);
		rw(OFS_TRACE, 8'h00);
		repeat (2) @(posedge clk);
		#1;
		chk(32'(core_busy), 32'h0);
		// Second reset with both straps low
		@(posedge clk);
		rst <= 1'b1;
		ext_rom_select_n <= 1'b0;
		boot_width_pin <= 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rr(OFS_BUS_WIDTH, r);
		chk(32'(r), 32'h0);
		access(1'b0, 2'h0, 32'h0000_0010, 32'h0, n, rd);
		chk({16'h0, rd[7:0], 8'(n)}, 32'h4A02);
		conclude();
	end
endmodule // ebac_ctrl_tb

/* verif/ebac_ext_model.sv */
// Partner model: external SRAM and DRAM devices, internal area responder
module ebac_ext_model import ebac_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pins seen by the devices
	input wire logic [25:0] external_address,
	input wire logic [15:0] xd_out,
	input wire logic chip_select_bank0_n,
	input wire logic chip_select_bank1_n,
	input wire logic read_strobe_n,
	input wire logic wre_or_wrl_n,
	input wire logic hb_or_wrh_n,
	input wire logic lb_or_a0,
	input wire logic ras_n,
	input wire logic cas_or_casl_n,
	input wire logic we_or_wl_n,
	input wire logic cash_or_wh_n,
	input wire ebac_int_req_t int_req,
	// Wait cycles a slow device asks for
	input wire logic [3:0] slow,
	// Answers
	output logic [15:0] xd_in,
	output logic external_wait_n,
	output logic int_ack,
	output logic [31:0] int_rdata,
	// Snooped strobes and addresses
	output logic [15:0] wr_data,
	output logic [2:0] wr_pins,
	output logic [2:0] dpins,
	output logic [25:0] row_cap,
	output logic [31:0] wr_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] last_r;
	logic [3:0] cnt_r;
	logic cs_low;
	logic col;
	assign cs_low = !chip_select_bank0_n || !chip_select_bank1_n;
	assign col = !ras_n && (!cas_or_casl_n || !cash_or_wh_n);
	// Data during a read strobe or a DRAM column phase; a released bus shows a changing pattern
	assign xd_in = (!read_strobe_n || col) ? {external_address[7:0] ^ 8'hC3,
		external_address[7:0] ^ 8'h5A} : ~last_r;
	// Wait line idles high; a slow device pulls it low after select
	assign external_wait_n = !(cs_low && cnt_r < slow);
	// Bus history and select counter
	always_ff @(posedge clk) begin
		last_r <= rst ? 16'h0000 : xd_in;
		cnt_r <= !cs_low ? 4'h0 : cnt_r + 4'(cnt_r != 4'hF);
	end
	// Internal areas answer one cycle after a request shows
	always_ff @(posedge clk) begin
		int_ack <= !rst && int_req.valid && !int_ack;
		int_rdata <= {6'h00, int_req.addr};
	end
	// Record write strobes, row address and DRAM strobe pattern
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_cnt <= 32'h0;
		end else if (cs_low && (!wre_or_wrl_n || !hb_or_wrh_n)) begin
			wr_data <= xd_out;
			wr_pins <= {wre_or_wrl_n, hb_or_wrh_n, lb_or_a0};
			wr_cnt <= wr_cnt + 32'h1;
		end
		if (!ras_n && cas_or_casl_n && cash_or_wh_n) row_cap <= external_address;
		if (!ras_n && (!we_or_wl_n || !cash_or_wh_n))
			dpins <= {cas_or_casl_n, we_or_wl_n, cash_or_wh_n};
	end
endmodule // ebac_ext_model
